// [software_watchdog_reset_status_tb.sv]
// Self-checking bench for the watchdog and reset-cause block.
// Assumes swd_pkg, swd_top and swd_core_model are compiled first.
`timescale 1ns/1ps
`default_nettype none
module software_watchdog_reset_status_tb;
  import swd_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, iack, ext_n, ack_en;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        pready, pslverr, wd_irq, fack, wd_rst, irq, err;
  logic [3:0]  ack_dly;
  int          num_errors, comparisons, seed, n, i;

  swd_top uut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .iack(iack),
    .external_reset_input_n(ext_n), .wd_irq(wd_irq),
    .forced_transfer_ack(fack), .wd_reset_out(wd_rst), .irq(irq));
  swd_core_model core (.pclk(pclk), .presetn(presetn), .wd_irq(wd_irq),
    .ack_en(ack_en), .ack_dly(ack_dly), .iack(iack));

  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end

  function automatic int period(input int p, input int d);
    return 1 << ((p != 0 ? EXP_BASE_SLOW : EXP_BASE_FAST) + 2 * d);
  endfunction
  function automatic logic sel(input int s);
    return s == 0 ? wd_irq : s == 1 ? fack : s == 2 ? wd_rst :
           s == 3 ? !wd_rst : !wd_irq;
  endfunction
  task automatic chk(input string nm, input logic [31:0] e, g);
    comparisons++;
    if (g !== e) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic report_and_stop;
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic wait_sig(input int s, input int lim);
    n = 0;
    while (sel(s) !== 1'b1 && n < lim) begin
      @(posedge pclk);
      n++;
    end
    if (n >= lim) begin
      num_errors++;
      report_and_stop();
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (k >= 20) begin
      num_errors++;
      report_and_stop();
    end
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic service;
    apb(1'b1, REG_SERVICE, {24'h0, KEY_FIRST});
    repeat ($unsigned($random(seed)) % 3) apb(1'b0, REG_SERVICE, 32'h0);
    apb(1'b1, REG_SERVICE, {24'h0, KEY_SECOND});
  endtask

  initial begin
    seed = 8;
    num_errors = 0;
    comparisons = 0;
    {presetn, psel, penable, pwrite, ack_en} = 5'h00;
    paddr = 8'h00;
    pwdata = 32'h0;
    ext_n = 1'b1;
    ack_dly = 4'h0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, REG_RESET_CAUSE, 32'h0);
    chk("reset_cause", 32'h80, rd);
    apb(1'b0, REG_PROT_CTRL, 32'h0);
    chk("control", 32'h0, rd);
    apb(1'b0, 8'h40, 32'h0);
    chk("unmapped", 32'h1, {31'h0, err});
    repeat (600) @(posedge pclk);
    chk("disabled irq", 32'h0, {31'h0, wd_irq});
    apb(1'b1, REG_IRQ_MASK, 32'h1);
    apb(1'b1, REG_PROT_CTRL, 32'h80);
    for (i = 0; i < 4; i++) begin
      repeat (200) @(posedge pclk);
      service();
    end
    chk("serviced irq", 32'h0, {31'h0, wd_irq});
    wait_sig(0, period(0, 0) + 20);
    chk("timeout late", 32'h1, n > period(0, 0) - 40);
    chk("irq out", 32'h1, {31'h0, irq});
    service();
    chk("irq after service", 32'h1, {31'h0, wd_irq});
    apb(1'b1, REG_PROT_CTRL, 32'h0);
    apb(1'b0, REG_PROT_CTRL, 32'h0);
    chk("locked control", 32'h80, rd);
    apb(1'b1, REG_IRQ_STATUS, 32'h1);
    chk("irq cleared", 32'h0, {31'h0, irq});
    ack_dly <= 4'($random(seed));
    ack_en <= 1'b1;
    wait_sig(4, 40);
    apb(1'b1, REG_PROT_CTRL, 32'h0);
    chk("acked", 32'h0, {31'h0, wd_irq});
    ack_en <= 1'b0;
    service();
    apb(1'b1, REG_PROT_CTRL, 32'h84);
    wait_sig(0, period(0, 0) + 20);
    wait_sig(1, period(0, 0) + 20);
    chk("fack late", 32'h1, n > period(0, 0) - 40);
    apb(1'b0, REG_PROT_CTRL, 32'h0);
    chk("fack flag", 32'h86, rd);
    ack_en <= 1'b1;
    repeat (20) @(posedge pclk);
    ack_en <= 1'b0;
    apb(1'b1, REG_PROT_CTRL, 32'h02);
    service();
    apb(1'b1, REG_PROT_CTRL, 32'hc0);
    wait_sig(2, period(0, 0) + 20);
    wait_sig(3, 20);
    repeat (4) @(posedge pclk);
    apb(1'b0, REG_RESET_CAUSE, 32'h0);
    chk("wd cause", 32'h20, rd);
    apb(1'b0, REG_PROT_CTRL, 32'h0);
    chk("control after", 32'h0, rd);
    apb(1'b1, REG_IRQ_STATUS, 32'h3);
    apb(1'b1, REG_PROT_CTRL, 32'h80);
    wait_sig(0, period(0, 0) + 20);
    apb(1'b0, REG_IRQ_STATUS, 32'h0);
    chk("irq status", 32'h1, rd);
    apb(1'b1, REG_IRQ_ACK, 32'h1);
    chk("soft ack", 32'h0, {31'h0, wd_irq});
    apb(1'b1, REG_RESET_CAUSE, 32'ha0);
    ext_n <= 1'b0;
    repeat (4) @(posedge pclk);
    ext_n <= 1'b1;
    repeat (6) @(posedge pclk);
    apb(1'b0, REG_RESET_CAUSE, 32'h0);
    chk("pin cause", 32'h80, rd);
    report_and_stop();
  end
endmodule
`default_nettype wire

// [swd_core_model.sv]
// Model of the processor core answering the watchdog interrupt.
// Assumes it shares the block's clock and reset.
`timescale 1ns/1ps
`default_nettype none
module swd_core_model (
  // Clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // Interrupt handshake
  input  wire logic       wd_irq,
  input  wire logic       ack_en,
  input  wire logic [3:0] ack_dly,
  output var  logic       iack
);
  logic [3:0] wait_reg;
  logic [3:0] wait_next;
  logic       iack_next;
  always_comb begin
    wait_next = (wd_irq && ack_en && !iack) ? wait_reg + 4'h1 : 4'h0;
    iack_next = wd_irq && ack_en && !iack && (wait_reg == ack_dly);
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wait_reg <= 4'h0;
      iack     <= 1'b0;
    end else begin
      wait_reg <= wait_next;
      iack     <= iack_next;
    end
  end
endmodule
`default_nettype wire

// [swd_pkg.sv]
// Package for the software watchdog and reset-cause block.
// Assumes a 250 MHz APB clock and 32-bit APB data.
package swd_pkg;

  // Register byte addresses.
  localparam logic [7:0] REG_RESET_CAUSE = 8'h00;
  localparam logic [7:0] REG_PROT_CTRL   = 8'h04;
  localparam logic [7:0] REG_SERVICE     = 8'h08;
  localparam logic [7:0] REG_IRQ_STATUS  = 8'h0c;
  localparam logic [7:0] REG_IRQ_MASK    = 8'h10;
  localparam logic [7:0] REG_IRQ_ACK     = 8'h14;

  // Reset-cause fields and reset value.
  localparam int         EXT_RST_BIT     = 7;
  localparam int         WD_RST_BIT      = 5;
  localparam logic [7:0] RESET_CAUSE_RST = 8'h80;

  // Protection control fields and reset value.
  localparam int         CTL_ENABLE      = 7;
  localparam int         CTL_RST_SEL     = 6;
  localparam int         CTL_PRESCALE    = 5;
  localparam int         CTL_DELAY_HI    = 4;
  localparam int         CTL_DELAY_LO    = 3;
  localparam int         CTL_FACK_EN     = 2;
  localparam int         CTL_FACK_SEEN   = 1;
  localparam logic [7:0] PROT_CTRL_RST   = 8'h00;

  // Service keys.
  localparam logic [7:0] KEY_FIRST       = 8'h55;
  localparam logic [7:0] KEY_SECOND      = 8'haa;

  // Timeout exponents: base 9 unprescaled, 22 prescaled, step 2 per code.
  localparam int         EXP_BASE_FAST   = 9;
  localparam int         EXP_BASE_SLOW   = 22;
  localparam int         CNT_W           = 29;

  // Status bits: 0 timeout, 1 forced acknowledge.
  localparam int         ST_TIMEOUT      = 0;
  localparam int         ST_FACK         = 1;

  // Internal reset pulse length in cycles.
  localparam logic [3:0] WD_RST_CYCLES   = 4'h8;

  typedef enum logic [2:0] {
    SWD_IDLE = 3'b001,
    SWD_IRQ  = 3'b010,
    SWD_RST  = 3'b100
  } swd_state_t;

endpackage

// [swd_top.sv]
// Software watchdog timer with reset-cause register, APB slave.
// Assumes one clock; the external reset pin is asynchronous to it.
`timescale 1ns/1ps
`default_nettype none

module swd_top (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output var  logic [31:0] prdata,
  output var  logic        pready,
  output var  logic        pslverr,
  // Core side
  input  wire logic        iack,
  input  wire logic        external_reset_input_n,
  output var  logic        wd_irq,
  output var  logic        forced_transfer_ack,
  output var  logic        wd_reset_out,
  output var  logic        irq
);
  import swd_pkg::*;

  // period table
  // Period in cycles for a given control byte.
  function automatic logic [CNT_W-1:0] period(input logic [7:0] c);
    int e;
    e = (c[CTL_PRESCALE] ? EXP_BASE_SLOW : EXP_BASE_FAST)
        + 2 * int'({c[CTL_DELAY_HI], c[CTL_DELAY_LO]});
    period = CNT_W'(1) << e;
  endfunction

  // ----------------------------------------------------------------------
  // Input synchroniser
  // ----------------------------------------------------------------------
  logic ext_s1_reg, ext_s2_reg, ext_seen_reg;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_s1_reg <= 1'b1;
      ext_s2_reg <= 1'b1;
    end else begin
      ext_s1_reg <= external_reset_input_n;
      ext_s2_reg <= ext_s1_reg;
    end
  end

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  swd_state_t       st_reg, st_next;
  logic [CNT_W-1:0] cnt_reg, cnt_next;
  logic [7:0]       ctl_reg, ctl_next;
  logic [7:0]       cause_reg, cause_next;
  logic             key_reg, key_next;
  logic             fack_reg, fack_next;
  logic [3:0]       rcnt_reg, rcnt_next;
  logic [1:0]       sts_reg, sts_next;
  logic [1:0]       msk_reg, msk_next;
  logic             ext_next;
  logic [31:0]      rd_next;
  logic             pready_next, err_next, irq_next;

  wire acc = psel && penable && !pready;
  wire wr  = acc && pwrite;
  wire [7:0] wb = pwdata[7:0];
  wire hit = (paddr == REG_RESET_CAUSE) || (paddr == REG_PROT_CTRL) ||
             (paddr == REG_SERVICE) || (paddr == REG_IRQ_STATUS) ||
             (paddr == REG_IRQ_MASK) || (paddr == REG_IRQ_ACK);

  always_comb begin
    st_next     = st_reg;
    cnt_next    = cnt_reg;
    ctl_next    = ctl_reg;
    cause_next  = cause_reg;
    key_next    = key_reg;
    fack_next   = 1'b0;
    rcnt_next   = rcnt_reg;
    sts_next    = sts_reg;
    msk_next    = msk_reg;
    ext_next    = ext_seen_reg;
    rd_next     = 32'h0;
    pready_next = acc;
    err_next    = acc && !hit;

    // Software write first, so hardware cause updates win.
    if (wr && paddr == REG_RESET_CAUSE) begin
      cause_next = wb;
    end

    if (!ext_s2_reg) begin
      ext_next = 1'b1;
    end else if (ext_seen_reg) begin
      ext_next   = 1'b0;
      cause_next = RESET_CAUSE_RST;
    end

    if (ctl_reg[CTL_ENABLE] && cnt_reg != '0) begin
      cnt_next = cnt_reg - CNT_W'(1);
    end

    if (wr && paddr == REG_SERVICE) begin
      if (wb == KEY_FIRST) begin
        key_next = 1'b1;
      end else if (wb == KEY_SECOND && key_reg) begin
        key_next = 1'b0;
        cnt_next = period(ctl_reg);
      end
    end

    case (st_reg)
      SWD_IDLE: begin
        if (ctl_reg[CTL_ENABLE] && cnt_reg == CNT_W'(1)) begin
          if (ctl_reg[CTL_RST_SEL]) begin
            st_next   = SWD_RST;
            rcnt_next = WD_RST_CYCLES;
          end else begin
            st_next  = SWD_IRQ;
            cnt_next = period(ctl_reg);
          end
        end
      end
      SWD_IRQ: begin
        if (iack) begin
          st_next = SWD_IDLE;
          cnt_next = period(ctl_reg);
        end else if (ctl_reg[CTL_FACK_EN] && cnt_reg == CNT_W'(1)) begin
          fack_next = 1'b1;
          ctl_next[CTL_FACK_SEEN] = 1'b1;
          cnt_next = period(ctl_reg);
        end
      end
      SWD_RST: begin
        rcnt_next = rcnt_reg - 4'h1;
        if (rcnt_reg == 4'h1) begin
          cause_next = 8'h0;
          cause_next[WD_RST_BIT] = 1'b1;
          ctl_next = PROT_CTRL_RST;
          cnt_next = period(PROT_CTRL_RST);
          key_next = 1'b0;
          st_next  = SWD_IDLE;
        end
      end
      default: st_next = SWD_IDLE;
    endcase

    if (st_reg == SWD_IDLE && st_next == SWD_IRQ) begin
      sts_next[ST_TIMEOUT] = 1'b1;
    end

    // Register writes.
    // locked while pending
    if (wr && paddr == REG_PROT_CTRL && st_reg != SWD_IRQ) begin
      ctl_next = {wb[7:2], ctl_reg[CTL_FACK_SEEN] & ~wb[CTL_FACK_SEEN], 1'b0};
    end
    if (wr && paddr == REG_IRQ_STATUS) begin
      sts_next = sts_next & ~wb[1:0];
    end
    if (wr && paddr == REG_IRQ_MASK) begin
      msk_next = wb[1:0];
    end
    if (wr && paddr == REG_IRQ_ACK && wb[0] && st_reg == SWD_IRQ) begin
      st_next = SWD_IDLE;
      cnt_next = period(ctl_reg);
    end
    if (fack_next) begin
      sts_next[ST_FACK] = 1'b1;
    end
    if (st_reg == SWD_IDLE && st_next == SWD_IRQ) begin
      sts_next[ST_TIMEOUT] = 1'b1;
    end

    if (acc && !pwrite) begin
      case (paddr)
        REG_RESET_CAUSE: rd_next = {24'h0, cause_reg};
        REG_PROT_CTRL:   rd_next = {24'h0, ctl_reg};
        REG_IRQ_STATUS:  rd_next = {30'h0, sts_reg};
        REG_IRQ_MASK:    rd_next = {30'h0, msk_reg};
        default:         rd_next = 32'h0;
      endcase
    end
    irq_next = |(sts_next & msk_next);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg       <= SWD_IDLE;
      ctl_reg      <= PROT_CTRL_RST;
      cnt_reg      <= CNT_W'(1) << EXP_BASE_FAST;
      cause_reg    <= RESET_CAUSE_RST;
      key_reg      <= 1'b0;
      fack_reg     <= 1'b0;
      rcnt_reg     <= 4'h0;
      sts_reg      <= 2'h0;
      msk_reg      <= 2'h0;
      ext_seen_reg <= 1'b0;
      prdata       <= 32'h0;
      pready       <= 1'b0;
      pslverr      <= 1'b0;
      irq          <= 1'b0;
      wd_irq       <= 1'b0;
      wd_reset_out <= 1'b0;
    end else begin
      st_reg       <= st_next;
      ctl_reg      <= ctl_next;
      cnt_reg      <= cnt_next;
      cause_reg    <= cause_next;
      key_reg      <= key_next;
      fack_reg     <= fack_next;
      rcnt_reg     <= rcnt_next;
      sts_reg      <= sts_next;
      msk_reg      <= msk_next;
      ext_seen_reg <= ext_next;
      prdata       <= rd_next;
      pready       <= pready_next;
      pslverr      <= err_next;
      irq          <= irq_next;
      wd_irq       <= (st_next == SWD_IRQ);
      wd_reset_out <= (st_next == SWD_RST);
    end
  end
  assign forced_transfer_ack = fack_reg;

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  a_cause_onehot: assert property (@(posedge pclk) disable iff (!presetn)
    (st_reg == SWD_RST && rcnt_reg == 4'h1) |=> $onehot(cause_reg))
    else $error("reset cause not one-hot");
  a_cause_late: assert property (@(posedge pclk) disable iff (!presetn)
    (wd_reset_out && $past(wd_reset_out)) |-> $stable(cause_reg[WD_RST_BIT]))
    else $error("cause changed during reset");
  a_ext_cause: assert property (@(posedge pclk) disable iff (!presetn)
    (ext_seen_reg && ext_s2_reg) |=> cause_reg == RESET_CAUSE_RST)
    else $error("external cause not recorded");
  a_wd_cause: assert property (@(posedge pclk) disable iff (!presetn)
    $fell(wd_reset_out) |-> cause_reg[WD_RST_BIT])
    else $error("watchdog cause not recorded");
  a_hold_off: assert property (@(posedge pclk) disable iff (!presetn)
    (!ctl_reg[CTL_ENABLE] && st_reg == SWD_IDLE && !wr) |=> $stable(cnt_reg))
    else $error("counter moved while disabled");
  a_rst_len: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(wd_reset_out) |-> wd_reset_out [*8] ##1 !wd_reset_out)
    else $error("internal reset length wrong");
  a_fack_flag: assert property (@(posedge pclk) disable iff (!presetn)
    forced_transfer_ack |-> ctl_reg[CTL_FACK_SEEN])
    else $error("forced ack flag not set");
  a_lock_ctrl: assert property (@(posedge pclk) disable iff (!presetn)
    (st_reg == SWD_IRQ && !forced_transfer_ack && !fack_next)
      |=> $stable(ctl_reg) || st_reg != SWD_IRQ)
    else $error("control changed while pending");
  a_irq_hold: assert property (@(posedge pclk) disable iff (!presetn)
    (wd_irq && !iack && !(wr && paddr == REG_IRQ_ACK)) |=> wd_irq)
    else $error("irq dropped without ack");

endmodule

`default_nettype wire
